// *** hw/mefi_top.v ***
// Event flags, interrupt routing and sample queue of the motion sensor.
`timescale 1ns/1ps
`default_nettype none
`include "mefi_consts.vh"
// Contract
// - Two interrupt outputs; enabled sources routed by pin select bit.
// - Data flags clear by data reads; others clear on cause register read.
// - New-sample flag is high while unread sample data remains.
// - Single knock: one hit above threshold shorter than knock duration.
// - Double knock: second hit starts after gap delay, within span.
// - Activity flag sets when acceleration exceeds motion threshold.
// - Inactivity sets after acceleration stays below still threshold past still time.
// - Drop sets when all axes stay below drop threshold past drop time.
// - Watermark high while queue level reaches the sample-count field.
// - Overrun on unread overwrite in bypass, on full queue otherwise.
// - 32-entry sample queue with bypass, fill-once, streaming, triggered modes.
// - Bypass keeps queue empty; data bytes show the latest sample.
// - Fill-once stores until full then refuses new samples.
// - Streaming keeps newest 32, dropping oldest when full.
// - Triggered keeps newest, trims to n on trigger, then fills once.
// - One trigger only until bypass, status read, then triggered again.
// - Outside bypass each data read pops the oldest sample into data bytes.
// - Single-byte data read discards rest of that queued sample.
// - Self-test bit adds a test force to the measured samples.
module mefi_top #(
  parameter TICK_CYC = `MEFI_TICK_NS / `MEFI_CLK_NS,
  parameter DEPTH = `MEFI_DEPTH,
  parameter AW = 5,
  parameter [15:0] ST_X = 16'h0040,
  parameter [15:0] ST_Y = 16'hffc0,
  parameter [15:0] ST_Z = 16'h0060
) (
  input wire clk,
  input wire rstn,
  input wire sel_n,
  input wire [5:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_ff,
  input wire smp_valid,
  input wire [15:0] smp_x,
  input wire [15:0] smp_y,
  input wire [15:0] smp_z,
  output reg irq_out_a_ff,
  output reg irq_out_b_ff,
  output wire self_test_en
);
  //////////////////////////////////////////////////////////////////////////////
  function [15:0] mefi_abs;
    input [15:0] v;
    begin
      mefi_abs = v[15] ? (~v + 16'h0001) : v;
    end
  endfunction

  function in_data;
    input [5:0] a;
    begin
      in_data = (a >= `MEFI_ADDR_DATA_FIRST) && (a <= `MEFI_ADDR_DATA_LAST);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  reg [7:0] knock_threshold_ff;
  reg [7:0] knock_duration_ff;
  reg [7:0] knock_gap_delay_ff;
  reg [7:0] second_knock_span_ff;
  reg [7:0] motion_threshold_ff;
  reg [7:0] still_threshold_ff;
  reg [7:0] still_drop_time;
  reg [7:0] drop_threshold_ff;
  reg [7:0] drop_drop_time;
  reg [7:0] irq_enable_ff;
  reg [7:0] irq_pin_select_ff;
  reg [7:0] output_format_ctrl_ff;
  reg [7:0] queue_control_ff;
  reg [7:0] sticky_ff;
  reg overrun_ff;
  reg unread_ff;
  reg [47:0] hold_ff;
  reg data_burst_ff;
  reg trig_done_ff;
  reg rearm_ok_ff;
  reg sel_meta_ff;
  reg sel_sync_ff;
  reg sel_prev_ff;
  reg [15:0] tick_cnt_ff;
  reg [10:0] sec_cnt_ff;
  reg [7:0] mag_ff;
  reg [8:0] still_cnt_ff;
  reg [10:0] drop_cnt_ff;
  reg motion_evt_ff;
  reg [7:0] nxt_rdata;

  wire [1:0] mode = queue_control_ff[`MEFI_QMODE_HI:`MEFI_QMODE_LO];
  wire bypass = (mode == `MEFI_MODE_BYPASS);
  wire [AW:0] samples_n = {1'b0, queue_control_ff[`MEFI_QSAMPLES_HI:0]};
  wire [AW:0] q_count;
  wire q_full;
  wire [47:0] q_head;
  wire single_evt;
  wire double_evt;

  //////////////////////////////////////////////////////////////////////////////
  // The select pin is asynchronous to clk; its rising edge is taken from the second and third flops.
  always @(posedge clk) begin
    if (!rstn) begin
      sel_meta_ff <= 1'b1;
      sel_sync_ff <= 1'b1;
      sel_prev_ff <= 1'b1;
    end else begin
      sel_meta_ff <= sel_n;
      sel_sync_ff <= sel_meta_ff;
      sel_prev_ff <= sel_sync_ff;
    end
  end
  wire sel_rise = sel_sync_ff & ~sel_prev_ff;

  //////////////////////////////////////////////////////////////////////////////
  // self-test force
  assign self_test_en = output_format_ctrl_ff[`MEFI_FMT_SELF_TEST];
  wire [15:0] ax = self_test_en ? (smp_x + ST_X) : smp_x;
  wire [15:0] ay = self_test_en ? (smp_y + ST_Y) : smp_y;
  wire [15:0] az = self_test_en ? (smp_z + ST_Z) : smp_z;
  wire [47:0] smp_word = {az, ay, ax};

  wire [15:0] abs_x = mefi_abs(ax);
  wire [15:0] abs_y = mefi_abs(ay);
  wire [15:0] abs_z = mefi_abs(az);
  wire [15:0] abs_xy = (abs_x > abs_y) ? abs_x : abs_y;
  wire [15:0] abs_max = (abs_xy > abs_z) ? abs_xy : abs_z;
  wire [15:0] abs_scaled = abs_max >> `MEFI_THR_SHIFT;
  wire [7:0] mag_now = (abs_scaled[15:8] != 8'h00) ? 8'hff : abs_scaled[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // Knock and drop detectors step on a 625 us tick, inactivity on a 1 s tick, so long times need no wide counters.
  wire tick = (tick_cnt_ff == TICK_CYC[15:0] - 16'h0001);
  wire sec_tick = tick && (sec_cnt_ff == `MEFI_TICKS_PER_SEC - 1);
  wire still_below = (mag_ff < still_threshold_ff);
  wire drop_below = (mag_ff < drop_threshold_ff);
  wire [10:0] drop_lim = {3'b000, drop_drop_time} << `MEFI_DROP_SHIFT;
  wire still_evt = sec_tick && still_below && (still_cnt_ff == {1'b0, still_drop_time});
  wire drop_evt = tick && drop_below && (drop_cnt_ff == drop_lim);

  always @(posedge clk) begin
    if (!rstn) begin
      tick_cnt_ff <= 16'h0000;
      sec_cnt_ff <= 11'h000;
      mag_ff <= 8'h00;
      still_cnt_ff <= 9'h000;
      drop_cnt_ff <= 11'h000;
      motion_evt_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
      if (tick) begin
        sec_cnt_ff <= sec_tick ? 11'h000 : sec_cnt_ff + 11'h001;
      end
      if (smp_valid) begin
        mag_ff <= mag_now;
      end
      motion_evt_ff <= smp_valid && (mag_now > motion_threshold_ff);
      if (!still_below) begin
        still_cnt_ff <= 9'h000;
      end else if (sec_tick && still_cnt_ff != 9'h1ff) begin
        still_cnt_ff <= still_cnt_ff + 9'h001;
      end
      if (!drop_below) begin
        drop_cnt_ff <= 11'h000;
      end else if (tick && drop_cnt_ff != 11'h7ff) begin
        drop_cnt_ff <= drop_cnt_ff + 11'h001;
      end
    end
  end

  mefi_knock u_knock (
    .clk(clk),
    .rstn(rstn),
    .tick(tick),
    .above(mag_ff > knock_threshold_ff),
    .knock_duration(knock_duration_ff),
    .knock_gap_delay(knock_gap_delay_ff),
    .second_knock_span(second_knock_span_ff),
    .single_evt_ff(single_evt),
    .double_evt_ff(double_evt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // a data read ends on leaving the data bytes or on select release
  wire rd_data = reg_rd && in_data(reg_addr);
  wire burst_end = data_burst_ff && ((reg_rd && !in_data(reg_addr)) || sel_rise);
  wire pop = burst_end && !bypass;
  // full queue refuses in fill-once and after a trigger
  wire push = smp_valid && !bypass &&
              (!q_full || mode == `MEFI_MODE_STREAM ||
               (mode == `MEFI_MODE_TRIG && !trig_done_ff));

  wire trig_level = queue_control_ff[`MEFI_QTRIG_PIN] ? irq_out_b_ff : irq_out_a_ff;
  reg trig_prev_ff;
  wire trigger = (mode == `MEFI_MODE_TRIG) && !trig_done_ff && trig_level && !trig_prev_ff;

  mefi_queue #(
    .DEPTH(DEPTH),
    .AW(AW),
    .DW(48)
  ) u_queue (
    .clk(clk),
    .rstn(rstn),
    .flush(bypass),
    .trim(trigger),
    .trim_n(samples_n),
    .push(push),
    .push_data(smp_word),
    .pop(pop),
    .head(q_head),
    .count(q_count),
    .full(q_full)
  );

  always @(posedge clk) begin
    if (!rstn) begin
      hold_ff <= 48'h000000000000;
      unread_ff <= 1'b0;
      data_burst_ff <= 1'b0;
      trig_done_ff <= 1'b0;
      rearm_ok_ff <= 1'b0;
      trig_prev_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end else begin
      trig_prev_ff <= trig_level;
      if (bypass && smp_valid) begin
        hold_ff <= smp_word;
      // head copied every cycle while the queue holds data
      end else if (!bypass && q_count != {(AW+1){1'b0}}) begin
        hold_ff <= q_head;
      end
      // bytes not read are gone after the pop
      if (burst_end) begin
        data_burst_ff <= 1'b0;
      end else if (rd_data) begin
        data_burst_ff <= 1'b1;
      end
      if (bypass && smp_valid) begin
        unread_ff <= 1'b1;
      end else if (burst_end || !bypass) begin
        unread_ff <= 1'b0;
      end
      if ((bypass && smp_valid && unread_ff) || (!bypass && smp_valid && q_full)) begin
        overrun_ff <= 1'b1;
      end else if (burst_end) begin
        overrun_ff <= 1'b0;
      end
      if (trigger) begin
        trig_done_ff <= 1'b1;
      end else if (mode == `MEFI_MODE_TRIG && rearm_ok_ff) begin
        trig_done_ff <= 1'b0;
        rearm_ok_ff <= 1'b0;
      end
      if (bypass && reg_rd && reg_addr == `MEFI_ADDR_QSTAT) begin
        rearm_ok_ff <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // ready while data is unread
  wire ready_lvl = bypass ? unread_ff : (q_count != {(AW+1){1'b0}});
  wire wmark_lvl = (q_count >= samples_n);
  wire [7:0] cause = {ready_lvl, sticky_ff[`MEFI_BIT_SINGLE:`MEFI_BIT_DROP], wmark_lvl, overrun_ff};
  wire cause_rd = reg_rd && (reg_addr == `MEFI_ADDR_IRQ_CAUSE);
  wire [7:0] evt_set = {1'b0, single_evt, double_evt, motion_evt_ff, still_evt, drop_evt, 2'b00};

  always @(posedge clk) begin
    if (!rstn) begin
      sticky_ff <= `MEFI_RST_BYTE;
      irq_out_a_ff <= 1'b0;
      irq_out_b_ff <= 1'b0;
    end else begin
      // cause read clears, a new event wins
      sticky_ff <= evt_set | (cause_rd ? 8'h00 : sticky_ff);
      irq_out_a_ff <= |(cause & irq_enable_ff & ~irq_pin_select_ff);
      irq_out_b_ff <= |(cause & irq_enable_ff & irq_pin_select_ff);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (!rstn) begin
      knock_threshold_ff <= `MEFI_RST_BYTE;
      knock_duration_ff <= `MEFI_RST_BYTE;
      knock_gap_delay_ff <= `MEFI_RST_BYTE;
      second_knock_span_ff <= `MEFI_RST_BYTE;
      motion_threshold_ff <= `MEFI_RST_BYTE;
      still_threshold_ff <= `MEFI_RST_BYTE;
      still_drop_time <= `MEFI_RST_BYTE;
      drop_threshold_ff <= `MEFI_RST_BYTE;
      drop_drop_time <= `MEFI_RST_BYTE;
      irq_enable_ff <= `MEFI_RST_BYTE;
      irq_pin_select_ff <= `MEFI_RST_BYTE;
      output_format_ctrl_ff <= `MEFI_RST_BYTE;
      queue_control_ff <= `MEFI_RST_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == `MEFI_ADDR_KNOCK_THR) begin
        knock_threshold_ff <= reg_wdata;
      end else if (reg_addr == `MEFI_ADDR_KNOCK_DUR) begin
        knock_duration_ff <= reg_wdata;
      end else if (reg_addr == `MEFI_ADDR_KNOCK_GAP) begin
        knock_gap_delay_ff <= reg_wdata;
      end else if (reg_addr == `MEFI_ADDR_KNOCK_SPAN) begin
        second_knock_span_ff <= reg_wdata;
      end else if (reg_addr == `MEFI_ADDR_MOTION_THR) begin
        motion_threshold_ff <= reg_wdata;
      end else if (reg_addr == `MEFI_ADDR_STILL_THR) begin
        still_threshold_ff <= reg_wdata;
      end else if (reg_addr == `MEFI_ADDR_STILL_TIME) begin
        still_drop_time <= reg_wdata;
      end else if (reg_addr == `MEFI_ADDR_DROP_THR) begin
        drop_threshold_ff <= reg_wdata;
      end else if (reg_addr == `MEFI_ADDR_DROP_TIME) begin
        drop_drop_time <= reg_wdata;
      end else if (reg_addr == `MEFI_ADDR_IRQ_EN) begin
        irq_enable_ff <= reg_wdata;
      end else if (reg_addr == `MEFI_ADDR_IRQ_PIN) begin
        irq_pin_select_ff <= reg_wdata;
      end else if (reg_addr == `MEFI_ADDR_FMT) begin
        output_format_ctrl_ff <= reg_wdata;
      end else if (reg_addr == `MEFI_ADDR_QCTRL) begin
        queue_control_ff <= reg_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always @* begin
    nxt_rdata = 8'h00;
    if (reg_addr == `MEFI_ADDR_KNOCK_THR) begin
      nxt_rdata = knock_threshold_ff;
    end else if (reg_addr == `MEFI_ADDR_KNOCK_DUR) begin
      nxt_rdata = knock_duration_ff;
    end else if (reg_addr == `MEFI_ADDR_KNOCK_GAP) begin
      nxt_rdata = knock_gap_delay_ff;
    end else if (reg_addr == `MEFI_ADDR_KNOCK_SPAN) begin
      nxt_rdata = second_knock_span_ff;
    end else if (reg_addr == `MEFI_ADDR_MOTION_THR) begin
      nxt_rdata = motion_threshold_ff;
    end else if (reg_addr == `MEFI_ADDR_STILL_THR) begin
      nxt_rdata = still_threshold_ff;
    end else if (reg_addr == `MEFI_ADDR_STILL_TIME) begin
      nxt_rdata = still_drop_time;
    end else if (reg_addr == `MEFI_ADDR_DROP_THR) begin
      nxt_rdata = drop_threshold_ff;
    end else if (reg_addr == `MEFI_ADDR_DROP_TIME) begin
      nxt_rdata = drop_drop_time;
    end else if (reg_addr == `MEFI_ADDR_IRQ_EN) begin
      nxt_rdata = irq_enable_ff;
    end else if (reg_addr == `MEFI_ADDR_IRQ_PIN) begin
      nxt_rdata = irq_pin_select_ff;
    end else if (reg_addr == `MEFI_ADDR_IRQ_CAUSE) begin
      nxt_rdata = cause;
    end else if (reg_addr == `MEFI_ADDR_FMT) begin
      nxt_rdata = output_format_ctrl_ff;
    end else if (in_data(reg_addr)) begin
      nxt_rdata = hold_ff[(reg_addr - `MEFI_ADDR_DATA_FIRST) * 8 +: 8];
    end else if (reg_addr == `MEFI_ADDR_QCTRL) begin
      nxt_rdata = queue_control_ff;
    end else if (reg_addr == `MEFI_ADDR_QSTAT) begin
      nxt_rdata = {trig_done_ff, 1'b0, q_count};
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end
endmodule // mefi_top
`default_nettype wire

// *** hw/mefi_consts.vh ***
// Constants shared by the motion event queue and interrupt block.
`ifndef MEFI_CONSTS_VH
`define MEFI_CONSTS_VH

`define MEFI_CLK_NS 40
`define MEFI_TICK_NS 625000
`define MEFI_TICKS_PER_SEC 1600
`define MEFI_DROP_SHIFT 3
`define MEFI_GAP_SHIFT 1
`define MEFI_DEPTH 32
`define MEFI_THR_SHIFT 4

`define MEFI_ADDR_KNOCK_THR 6'h1d
`define MEFI_ADDR_KNOCK_DUR 6'h21
`define MEFI_ADDR_KNOCK_GAP 6'h22
`define MEFI_ADDR_KNOCK_SPAN 6'h23
`define MEFI_ADDR_MOTION_THR 6'h24
`define MEFI_ADDR_STILL_THR 6'h25
`define MEFI_ADDR_STILL_TIME 6'h26
`define MEFI_ADDR_DROP_THR 6'h28
`define MEFI_ADDR_DROP_TIME 6'h29
`define MEFI_ADDR_IRQ_EN 6'h2e
`define MEFI_ADDR_IRQ_PIN 6'h2f
`define MEFI_ADDR_IRQ_CAUSE 6'h30
`define MEFI_ADDR_FMT 6'h31
`define MEFI_ADDR_DATA_FIRST 6'h32
`define MEFI_ADDR_DATA_LAST 6'h37
`define MEFI_ADDR_QCTRL 6'h38
`define MEFI_ADDR_QSTAT 6'h39

`define MEFI_BIT_READY 7
`define MEFI_BIT_SINGLE 6
`define MEFI_BIT_DOUBLE 5
`define MEFI_BIT_MOTION 4
`define MEFI_BIT_STILL 3
`define MEFI_BIT_DROP 2
`define MEFI_BIT_WMARK 1
`define MEFI_BIT_OVERRUN 0

`define MEFI_FMT_SELF_TEST 7
`define MEFI_QMODE_HI 7
`define MEFI_QMODE_LO 6
`define MEFI_QTRIG_PIN 5
`define MEFI_QSAMPLES_HI 4
`define MEFI_QSTAT_TRIG 7

`define MEFI_MODE_BYPASS 2'h0
`define MEFI_MODE_FILL 2'h1
`define MEFI_MODE_STREAM 2'h2
`define MEFI_MODE_TRIG 2'h3

`define MEFI_RST_BYTE 8'h00

`endif

// *** hw/mefi_queue.v ***
// Ring buffer of three-axis samples with push, pop, flush and trim.
`timescale 1ns/1ps
`default_nettype none
module mefi_queue #(
  parameter DEPTH = 32,
  parameter AW = 5,
  parameter DW = 48
) (
  input wire clk,
  input wire rstn,
  input wire flush,
  input wire trim,
  input wire [AW:0] trim_n,
  input wire push,
  input wire [DW-1:0] push_data,
  input wire pop,
  output wire [DW-1:0] head,
  output wire [AW:0] count,
  output wire full
);
  reg [DW-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire do_pop;
  wire drop_old;

  assign full = (count_ff == DEPTH[AW:0]);
  assign head = mem_ff[rd_ptr_ff];
  assign count = count_ff;
  // A push into a full buffer drops the oldest entry to make room.
  assign drop_old = push & full;
  assign do_pop = (pop & (count_ff != {(AW+1){1'b0}})) | drop_old;

  always @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= push_data;
    end
  end

  always @(posedge clk) begin
    if (!rstn || flush) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else if (trim) begin
      if (count_ff > trim_n) begin
        rd_ptr_ff <= wr_ptr_ff - trim_n[AW-1:0];
        count_ff <= trim_n;
      end
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !do_pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (!push && do_pop) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule // mefi_queue
`default_nettype wire

// *** hw/mefi_knock.v ***
// Single and double knock detector stepped by the 625 us tick.
`timescale 1ns/1ps
`default_nettype none
module mefi_knock (
  input wire clk,
  input wire rstn,
  input wire tick,
  input wire above,
  input wire [7:0] knock_duration,
  input wire [7:0] knock_gap_delay,
  input wire [7:0] second_knock_span,
  output reg single_evt_ff,
  output reg double_evt_ff
);
  localparam ST_IDLE = 3'b000;
  localparam ST_HIT1 = 3'b001;
  localparam ST_GAP = 3'b010;
  localparam ST_SPAN = 3'b011;
  localparam ST_HIT2 = 3'b100;
  localparam ST_QUIET = 3'b101;

  reg [2:0] state_ff;
  reg [9:0] cnt_ff;
  wire [9:0] cnt_inc = cnt_ff + 10'h001;
  wire [9:0] dur_lim = {2'b00, knock_duration};
  wire [9:0] gap_lim = {2'b00, knock_gap_delay} << `MEFI_GAP_SHIFT;
  wire [9:0] span_lim = {2'b00, second_knock_span} << `MEFI_GAP_SHIFT;

  always @(posedge clk) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 10'h000;
      single_evt_ff <= 1'b0;
      double_evt_ff <= 1'b0;
    end else begin
      single_evt_ff <= 1'b0;
      double_evt_ff <= 1'b0;
      if (tick) begin
        case (state_ff)
          ST_IDLE: begin
            cnt_ff <= 10'h000;
            if (above && knock_duration != 8'h00) begin
              state_ff <= ST_HIT1;
            end
          end
          ST_HIT1: begin
            if (above) begin
              cnt_ff <= cnt_inc;
              if (cnt_inc >= dur_lim) begin
                state_ff <= ST_QUIET;
              end
            end else begin
              single_evt_ff <= 1'b1;
              cnt_ff <= 10'h000;
              if (gap_lim != 10'h000 && span_lim != 10'h000) begin
                state_ff <= ST_GAP;
              end else begin
                state_ff <= ST_IDLE;
              end
            end
          end
          ST_GAP: begin
            cnt_ff <= cnt_inc;
            if (cnt_inc >= gap_lim) begin
              cnt_ff <= 10'h000;
              state_ff <= ST_SPAN;
            end
          end
          ST_SPAN: begin
            if (above) begin
              cnt_ff <= 10'h000;
              state_ff <= ST_HIT2;
            end else begin
              cnt_ff <= cnt_inc;
              if (cnt_inc >= span_lim) begin
                state_ff <= ST_IDLE;
              end
            end
          end
          ST_HIT2: begin
            if (above) begin
              cnt_ff <= cnt_inc;
              if (cnt_inc >= dur_lim) begin
                state_ff <= ST_QUIET;
              end
            end else begin
              double_evt_ff <= 1'b1;
              state_ff <= ST_IDLE;
            end
          end
          ST_QUIET: begin
            if (!above) begin
              state_ff <= ST_IDLE;
            end
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // mefi_knock
`default_nettype wire

// *** test/mefi_props.sv ***
// Port assertions for the motion event queue and interrupt block.
`timescale 1ns/1ps
`default_nettype none
module mefi_props (
  input wire clk,
  input wire rstn,
  input wire [5:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_ff,
  input wire irq_out_a_ff,
  input wire irq_out_b_ff,
  input wire self_test_en
);
  reg [7:0] en_ff;
  reg [7:0] pin_ff;
  reg [1:0] mode_ff;
  wire mapped = reg_addr == 6'h1d || (reg_addr >= 6'h21 && reg_addr <= 6'h29
    && reg_addr != 6'h27) || (reg_addr >= 6'h2e && reg_addr <= 6'h39);
  // Shadows of the enable, pin select and mode fields, so the checks need no design internals.
  always @(posedge clk) begin
    if (!rstn) begin
      en_ff <= 8'h00;
      pin_ff <= 8'h00;
      mode_ff <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == 6'h2e) en_ff <= reg_wdata;
      if (reg_addr == 6'h2f) pin_ff <= reg_wdata;
      if (reg_addr == 6'h38) mode_ff <= reg_wdata[7:6];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_none_to_a;
    ((en_ff & ~pin_ff) == 8'h00) [*3];
  endsequence
  sequence s_none_to_b;
    ((en_ff & pin_ff) == 8'h00) [*3];
  endsequence
  sequence s_bypass_held;
    (mode_ff == 2'h0) [*2] ##0 (reg_rd && reg_addr == 6'h39);
  endsequence
  a_irq_a_masked: assert property (
    s_none_to_a |-> !irq_out_a_ff) else $error("pin a raised with no source");
  a_irq_b_masked: assert property (
    s_none_to_b |-> !irq_out_b_ff) else $error("pin b raised with no source");
  a_enable_readback: assert property (
    reg_rd && reg_addr == 6'h2e |=> reg_rdata_ff == $past(en_ff)) else $error("enable readback");
  a_bypass_empty: assert property (
    s_bypass_held |=> reg_rdata_ff[5:0] == 6'h00) else $error("queue not empty in bypass");
  a_st_follows_write: assert property (
    reg_wr && reg_addr == 6'h31 |=> self_test_en == $past(reg_wdata[7]))
    else $error("self test bit not taken");
  a_st_holds: assert property (
    !(reg_wr && reg_addr == 6'h31) |=> $stable(self_test_en)) else $error("self test moved");
  a_unmapped_zero: assert property (
    reg_rd && !mapped |=> reg_rdata_ff == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds: assert property (
    !reg_rd |=> $stable(reg_rdata_ff)) else $error("read data moved without read");
endmodule // mefi_props
bind mefi_top mefi_props u_props (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
  .irq_out_a_ff(irq_out_a_ff), .irq_out_b_ff(irq_out_b_ff), .self_test_en(self_test_en));
`default_nettype wire

// *** test/mefi_host.sv ***
// Host controller model driving the register port of the block.
`timescale 1ns/1ps
`default_nettype none
module mefi_host (
  input wire clk,
  input wire [7:0] reg_rdata_ff,
  output logic sel_n,
  output logic [5:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  initial begin
    sel_n = 1'b0;
    reg_addr = 6'h3f;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk) #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge clk) #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk) #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    v = reg_rdata_ff;
  endtask
  task automatic end_burst();
    @(posedge clk) #1 sel_n = 1'b1;
    repeat (8) @(posedge clk);
    #1 sel_n = 1'b0;
    repeat (125) @(posedge clk);
  endtask
endmodule // mefi_host
`default_nettype wire

// *** test/mefi_top_tb.sv ***
// Self-checking bench for the motion event queue and interrupt block.
`timescale 1ns/1ps
`default_nettype none
module mefi_top_tb;
  localparam logic [47:0] ST = {16'h0060, 16'hffc0, 16'h0040};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic smp_valid = 1'b0;
  logic [47:0] smp = 48'h0;
  wire sel_n, reg_wr, reg_rd, irq_a, irq_b, st_en;
  wire [5:0] addr;
  wire [7:0] wdata, rdata;
  logic [7:0] d, v;
  logic [47:0] s, g;
  logic [47:0] q[$];
  logic [5:0] rw[13] = '{6'h1d, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h28, 6'h29,
    6'h2e, 6'h2f, 6'h31, 6'h38};
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  mefi_host host (.clk(clk), .reg_rdata_ff(rdata), .sel_n(sel_n), .reg_addr(addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(wdata));
  mefi_top #(.TICK_CYC(4), .ST_X(ST[15:0]), .ST_Y(ST[31:16]), .ST_Z(ST[47:32])) uut (
    .clk(clk), .rstn(rstn), .sel_n(sel_n), .reg_addr(addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(wdata), .reg_rdata_ff(rdata), .smp_valid(smp_valid), .smp_x(smp[15:0]),
    .smp_y(smp[31:16]), .smp_z(smp[47:32]), .irq_out_a_ff(irq_a), .irq_out_b_ff(irq_b),
    .self_test_en(st_en));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] x);
    check_count++;
    if (x !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, x);
    end
  endtask
  task automatic rchk(input string n, input logic [5:0] a, input logic [7:0] m, e);
    host.rd(a, d);
    chk(n, e, d & m);
  endtask
  function automatic logic [47:0] rnd();
    return {16'($urandom), 16'($urandom), 16'($urandom)};
  endfunction
  function automatic logic [47:0] with_st(input logic [47:0] a);
    return {a[47:32] + ST[47:32], a[31:16] + ST[31:16], a[15:0] + ST[15:0]};
  endfunction
  task automatic push(input logic [47:0] a);
    @(posedge clk) #1;
    smp = a;
    smp_valid = 1'b1;
    @(posedge clk) #1;
    smp_valid = 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic burst(output logic [47:0] x);
    for (int i = 0; i < 6; i++) begin
      host.rd(6'h32 + 6'(i), d);
      x[8*i +: 8] = d;
    end
    host.end_burst();
  endtask
  task automatic do_reset();
    @(posedge clk) #1;
    rstn = 1'b0;
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
  endtask
  task automatic fill(input int n, input bit keep_new);
    q.delete();
    for (int i = 0; i < n; i++) begin
      s = rnd();
      push(s);
      if (q.size() == 32 && keep_new) q.delete(0);
      if (q.size() < 32) q.push_back(s);
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(91989));
    do_reset();
    for (int a = 'h1d; a <= 'h3a; a++) begin
      host.rd(6'(a), d);
      chk("reset value", (a == 'h30) ? 8'h02 : 8'h00, d);
    end
    foreach (rw[k]) begin
      v = 8'($urandom);
      host.wr(rw[k], v);
      host.rd(rw[k], d);
      chk("readback", v, d);
    end
    do_reset();
    host.wr(6'h39, 8'hff);
    rchk("read only status", 6'h39, 8'hff, 8'h00);
    host.wr(6'h2e, 8'h00);
    host.wr(6'h24, 8'h10);
    host.wr(6'h2f, 8'h80);
    host.wr(6'h2e, 8'h81);
    s = rnd();
    s[15:0] = 16'h0200;
    push(s);
    chk("pin b", 2'b10, {irq_b, irq_a});
    rchk("cause", 6'h30, 8'h9f, 8'h92);
    rchk("cause cleared", 6'h30, 8'h9f, 8'h82);
    burst(g);
    chk("bypass data", s, g);
    rchk("ready cleared", 6'h30, 8'h83, 8'h02);
    push(rnd());
    s = rnd();
    push(s);
    chk("both pins", 2'b11, {irq_b, irq_a});
    burst(g);
    chk("latest sample", s, g);
    rchk("overrun cleared", 6'h30, 8'h83, 8'h02);
    host.wr(6'h31, 8'h80);
    chk("self test pin", 1'b1, st_en);
    s = rnd();
    push(s);
    burst(g);
    chk("self test data", with_st(s), g);
    host.wr(6'h31, 8'h00);
    host.wr(6'h38, 8'h50);
    fill(34, 1'b0);
    rchk("fill count", 6'h39, 8'hff, 8'h20);
    rchk("wm overrun", 6'h30, 8'h03, 8'h03);
    host.rd(6'h32, d);
    host.end_burst();
    chk("single byte", q.pop_front() & 48'hff, d);
    for (int i = 0; i < 16; i++) begin
      burst(g);
      chk("pop data", q.pop_front(), g);
    end
    rchk("count after pops", 6'h39, 8'hff, 8'h0f);
    rchk("wm cleared", 6'h30, 8'h03, 8'h00);
    host.wr(6'h38, 8'h00);
    host.wr(6'h38, 8'h90);
    fill(35, 1'b1);
    rchk("stream count", 6'h39, 8'hff, 8'h20);
    burst(g);
    chk("stream oldest", q[0], g);
    host.wr(6'h2e, 8'h00);
    host.wr(6'h2f, 8'h00);
    host.wr(6'h1d, 8'h10);
    host.wr(6'h21, 8'h10);
    host.wr(6'h28, 8'h08);
    push(48'h7fff);
    push(48'h0);
    rchk("knock drop", 6'h30, 8'h44, 8'h44);
    host.wr(6'h38, 8'h00);
    host.wr(6'h38, 8'hc4);
    host.wr(6'h2e, 8'h02);
    fill(36, 1'b0);
    rchk("trigger status", 6'h39, 8'hff, 8'ha0);
    burst(g);
    chk("trigger oldest", q[0], g);
    host.wr(6'h38, 8'h00);
    host.rd(6'h39, d);
    host.wr(6'h38, 8'hc4);
    rchk("rearmed", 6'h39, 8'hff, 8'h00);
    end_sim();
  end
endmodule // mefi_top_tb
`default_nettype wire
